// ===== verilog/aem_regs.sv
// Purpose: Alert-mask registers, energy accumulator and tick counter behind the host port
// Assumes: Serial host front end presents byte reads and single-cycle byte write strobes
// Notes: Multi-byte counters are little endian; lowest address holds bits 7:0
//
// Overview of operation
// - Aux mask bits 5:0 hold upper/lower enables for aux inputs 2,3,4.
// - Set lower enable alerts on reading below limit; clear enable suppresses it.
// - Analog-pin mask bits 7:0 hold upper/lower pairs for pins 1 to 4.
// - Output mask: divided sense in bits 7:6, switch node in 5:4.
// - Difference mask: aux 2-1 in bits 7:6, aux 4-3 in 5:4.
// - Difference mask: pin 2-1 in bits 3:2, pin 4-3 in 1:0.
// - Every enable is 1 to enable, and resets to 0.
// - Energy kept in 48-bit accumulator resetting to zero.
// - Energy at bytes 0x7a to 0x7f, host readable and writable.
// - 32-bit tick counter counts accumulated conversion cycles.
// - Tick counter at bytes 0x80 to 0x83, readable, writable, resets zero.
// - Meter reset bit holds accumulator and counter at zero until cleared.
// - Meter halt bit freezes accumulator and counter.
// - Tick overflow flag sets when the counter wraps.
// - Energy overflow flag sets when the accumulator wraps.
`timescale 1ns/100ps
module aem_regs (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Host register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Power conversion results
  input wire logic power_done,
  input wire logic [aem_pkg::AEM_POWER_W-1:0] power_value,
  // Channel comparisons
  input wire logic [aem_pkg::AEM_NCH-1:0] ch_done,
  input wire logic [aem_pkg::AEM_NCH-1:0] ch_above_upper,
  input wire logic [aem_pkg::AEM_NCH-1:0] ch_below_lower,
  // Alert outputs
  output logic [aem_pkg::AEM_NCH-1:0] ch_alert,
  output logic alert_any
);
  import aem_pkg::*;

  logic [7:0] aux_mask_q;
  logic [7:0] gp_mask_q;
  logic [7:0] out_mask_q;
  logic [7:0] diff_mask_q;
  logic meter_reset_q;
  logic meter_halt_q;
  logic tick_ovf_q;
  logic energy_ovf_q;
  logic [AEM_ENERGY_W-1:0] energy_q;
  logic [AEM_ENERGY_W-1:0] energy_d;
  logic [AEM_TICK_W-1:0] tick_q;
  logic [AEM_TICK_W-1:0] tick_d;
  logic energy_carry;
  logic tick_carry;
  logic meter_step;
  logic [AEM_NCH-1:0] upper_en;
  logic [AEM_NCH-1:0] lower_en;
  aem_alert_if alert_bus ();

  // Address decode helpers for the multi-byte counters
  logic energy_hit;
  logic tick_hit;
  logic [2:0] energy_idx;
  logic [1:0] tick_idx;
  assign energy_hit = (reg_addr >= AEM_ENERGY_ADDR) &&
                      (reg_addr < AEM_ENERGY_ADDR + 8'(AEM_ENERGY_BYTES));
  assign tick_hit = (reg_addr >= AEM_TICK_ADDR) && (reg_addr < AEM_TICK_ADDR + 8'(AEM_TICK_BYTES));
  assign energy_idx = 3'(reg_addr - AEM_ENERGY_ADDR);
  assign tick_idx = 2'(reg_addr - AEM_TICK_ADDR);

  // Mask registers; reserved bits are never stored so they read as zero
  // enables reset clear
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      aux_mask_q <= AEM_MASK_RESET;
      gp_mask_q <= AEM_MASK_RESET;
      out_mask_q <= AEM_MASK_RESET;
      diff_mask_q <= AEM_MASK_RESET;
    end else if (reg_wr) begin
      if (reg_addr == AEM_AUX_MASK_ADDR) aux_mask_q <= reg_wdata & AEM_AUX_MASK_BITS;
      if (reg_addr == AEM_GP_MASK_ADDR) gp_mask_q <= reg_wdata & AEM_FULL_MASK_BITS;
      if (reg_addr == AEM_OUT_MASK_ADDR) out_mask_q <= reg_wdata & AEM_OUT_MASK_BITS;
      if (reg_addr == AEM_DIFF_MASK_ADDR) diff_mask_q <= reg_wdata & AEM_FULL_MASK_BITS;
    end
  end

  // Meter control bits; overflow flags are sticky, set wins over clear
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      meter_reset_q <= 1'b0;
      meter_halt_q <= 1'b0;
      tick_ovf_q <= 1'b0;
      energy_ovf_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == AEM_CTRL_ADDR) begin
        meter_reset_q <= reg_wdata[AEM_CTRL_RESET_BIT];
        meter_halt_q <= reg_wdata[AEM_CTRL_HALT_BIT];
        tick_ovf_q <= reg_wdata[AEM_CTRL_TICK_OVF_BIT];
        energy_ovf_q <= reg_wdata[AEM_CTRL_ENERGY_OVF_BIT];
      end
      if (meter_step && tick_carry) tick_ovf_q <= 1'b1;
      if (meter_step && energy_carry) energy_ovf_q <= 1'b1;
    end
  end

  assign meter_step = power_done && !meter_halt_q && !meter_reset_q;
  assign {energy_carry, energy_d} = {1'b0, energy_q} + {{(AEM_ENERGY_W+1-AEM_POWER_W){1'b0}}, power_value};
  assign {tick_carry, tick_d} = {1'b0, tick_q} + {{AEM_TICK_W{1'b0}}, 1'b1};

  // Energy accumulator; a host byte write in the same cycle overrides the step
  always_ff @(posedge ref_clk) begin
    if (!rst_b || meter_reset_q) begin
      energy_q <= AEM_ENERGY_RESET;
    end else if (reg_wr && energy_hit) begin
      energy_q[energy_idx*8 +: 8] <= reg_wdata;
    end else if (meter_step) begin
      energy_q <= energy_d;
    end
  end

  // Tick counter, same priority as the accumulator
  always_ff @(posedge ref_clk) begin
    if (!rst_b || meter_reset_q) begin
      tick_q <= AEM_TICK_RESET;
    end else if (reg_wr && tick_hit) begin
      tick_q[tick_idx*8 +: 8] <= reg_wdata;
    end else if (meter_step) begin
      tick_q <= tick_d;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    reg_rdata = 8'h00;
    if (reg_addr == AEM_AUX_MASK_ADDR) reg_rdata = aux_mask_q;
    else if (reg_addr == AEM_GP_MASK_ADDR) reg_rdata = gp_mask_q;
    else if (reg_addr == AEM_OUT_MASK_ADDR) reg_rdata = out_mask_q;
    else if (reg_addr == AEM_DIFF_MASK_ADDR) reg_rdata = diff_mask_q;
    else if (reg_addr == AEM_CTRL_ADDR) begin
      reg_rdata[AEM_CTRL_RESET_BIT] = meter_reset_q;
      reg_rdata[AEM_CTRL_HALT_BIT] = meter_halt_q;
      reg_rdata[AEM_CTRL_TICK_OVF_BIT] = tick_ovf_q;
      reg_rdata[AEM_CTRL_ENERGY_OVF_BIT] = energy_ovf_q;
    end
    else if (energy_hit) reg_rdata = energy_q[energy_idx*8 +: 8];
    else if (tick_hit) reg_rdata = tick_q[tick_idx*8 +: 8];
  end

  // Enable vectors, upper bit of each pair sits above the lower bit
  always_comb begin
    upper_en = '0;
    lower_en = '0;
    {upper_en[AEM_CH_AUX2], lower_en[AEM_CH_AUX2], upper_en[AEM_CH_AUX3], lower_en[AEM_CH_AUX3],
     upper_en[AEM_CH_AUX4], lower_en[AEM_CH_AUX4]} = aux_mask_q[5:0];
    {upper_en[AEM_CH_GP1], lower_en[AEM_CH_GP1], upper_en[AEM_CH_GP2], lower_en[AEM_CH_GP2],
     upper_en[AEM_CH_GP3], lower_en[AEM_CH_GP3], upper_en[AEM_CH_GP4], lower_en[AEM_CH_GP4]} = gp_mask_q;
    {upper_en[AEM_CH_OUT_SENSE], lower_en[AEM_CH_OUT_SENSE],
     upper_en[AEM_CH_SW_NODE], lower_en[AEM_CH_SW_NODE]} = out_mask_q[7:4];
    {upper_en[AEM_CH_AUX_DIFF_A], lower_en[AEM_CH_AUX_DIFF_A],
     upper_en[AEM_CH_AUX_DIFF_B], lower_en[AEM_CH_AUX_DIFF_B]} = diff_mask_q[7:4];
    {upper_en[AEM_CH_GP_DIFF_A], lower_en[AEM_CH_GP_DIFF_A],
     upper_en[AEM_CH_GP_DIFF_B], lower_en[AEM_CH_GP_DIFF_B]} = diff_mask_q[3:0];
  end

  assign alert_bus.upper_en = upper_en;
  assign alert_bus.lower_en = lower_en;
  assign alert_bus.conv_done = ch_done;
  assign alert_bus.above_upper = ch_above_upper;
  assign alert_bus.below_lower = ch_below_lower;

  aem_alert_eval u_eval (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .ch(alert_bus.eval)
  );

  assign ch_alert = alert_bus.alert;
  assign alert_any = |alert_bus.alert;

  // Checks
  sequence s_step;
    power_done && !meter_halt_q && !meter_reset_q && !(reg_wr && (energy_hit || tick_hit));
  endsequence
  AST_ENERGY_ADD: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_step |=> energy_q == $past(energy_q) + AEM_ENERGY_W'($past(power_value)))
    else $error("energy did not add power result");
  AST_TICK_INC: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_step |=> tick_q == $past(tick_q) + 32'h0000_0001)
    else $error("tick counter did not step by one");
  AST_HALT_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (meter_halt_q && !meter_reset_q && !reg_wr) |=> $stable(energy_q) && $stable(tick_q))
    else $error("meter moved while halted");
  AST_RESET_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_b)
    meter_reset_q |=> energy_q == AEM_ENERGY_RESET && tick_q == AEM_TICK_RESET)
    else $error("meter not held at zero");
  AST_TICK_OVF: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (meter_step && tick_q == '1) |=> tick_ovf_q)
    else $error("tick wrap not flagged");
  AST_ENERGY_OVF: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (meter_step && energy_carry) |=> energy_ovf_q)
    else $error("energy wrap not flagged");
  AST_ENERGY_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (reg_wr && reg_addr == AEM_ENERGY_ADDR && !meter_reset_q) |=> energy_q[7:0] == $past(reg_wdata))
    else $error("energy low byte not written");
  AST_TICK_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (reg_wr && reg_addr == AEM_TICK_ADDR + 8'h03 && !meter_reset_q) |=> tick_q[31:24] == $past(reg_wdata))
    else $error("tick top byte not written");
  AST_MASK_RESET: assert property (@(posedge ref_clk)
    !rst_b |=> aux_mask_q == AEM_MASK_RESET && gp_mask_q == AEM_MASK_RESET &&
               out_mask_q == AEM_MASK_RESET && diff_mask_q == AEM_MASK_RESET)
    else $error("mask not cleared by reset");
  AST_OUT_MAP: assert property (@(posedge ref_clk) disable iff (!rst_b)
    upper_en[AEM_CH_OUT_SENSE] == out_mask_q[7] && lower_en[AEM_CH_SW_NODE] == out_mask_q[4])
    else $error("output mask mapping wrong");
  AST_GP_MAP: assert property (@(posedge ref_clk) disable iff (!rst_b)
    upper_en[AEM_CH_GP1] == gp_mask_q[7] && lower_en[AEM_CH_GP4] == gp_mask_q[0])
    else $error("pin mask mapping wrong");
  AST_AUX_MAP: assert property (@(posedge ref_clk) disable iff (!rst_b)
    upper_en[AEM_CH_AUX2] == aux_mask_q[5] && lower_en[AEM_CH_AUX4] == aux_mask_q[0])
    else $error("aux mask mapping wrong");
  AST_DIFF_MAP: assert property (@(posedge ref_clk) disable iff (!rst_b)
    upper_en[AEM_CH_AUX_DIFF_A] == diff_mask_q[7] && lower_en[AEM_CH_AUX_DIFF_B] == diff_mask_q[4])
    else $error("aux difference mapping wrong");
  AST_GPDIFF_MAP: assert property (@(posedge ref_clk) disable iff (!rst_b)
    upper_en[AEM_CH_GP_DIFF_A] == diff_mask_q[3] && lower_en[AEM_CH_GP_DIFF_B] == diff_mask_q[0])
    else $error("pin difference mapping wrong");
endmodule : aem_regs

// ===== verilog/aem_pkg.sv
// Purpose: Shared constants for the alert-mask and energy-meter register bank
// Assumes: Byte-wide register access from the serial host front end
// Notes: Offsets are byte addresses on the host register map
package aem_pkg;
  // Register byte addresses
  localparam logic [7:0] AEM_AUX_MASK_ADDR = 8'h17;
  localparam logic [7:0] AEM_GP_MASK_ADDR = 8'h18;
  localparam logic [7:0] AEM_OUT_MASK_ADDR = 8'h19;
  localparam logic [7:0] AEM_DIFF_MASK_ADDR = 8'h1a;
  localparam logic [7:0] AEM_ENERGY_ADDR = 8'h7a;
  localparam logic [7:0] AEM_TICK_ADDR = 8'h80;
  localparam logic [7:0] AEM_CTRL_ADDR = 8'h84;
  // Sizes
  localparam int AEM_ENERGY_BYTES = 6;
  localparam int AEM_TICK_BYTES = 4;
  localparam int AEM_ENERGY_W = 48;
  localparam int AEM_TICK_W = 32;
  localparam int AEM_POWER_W = 24;
  localparam int AEM_NCH = 16;
  // Writable bits per mask register; reserved bits read as zero
  localparam logic [7:0] AEM_AUX_MASK_BITS = 8'h3f;
  localparam logic [7:0] AEM_OUT_MASK_BITS = 8'hf0;
  localparam logic [7:0] AEM_FULL_MASK_BITS = 8'hff;
  localparam logic [7:0] AEM_MASK_RESET = 8'h00;
  // Control register fields
  localparam int AEM_CTRL_RESET_BIT = 7;
  localparam int AEM_CTRL_HALT_BIT = 6;
  localparam int AEM_CTRL_TICK_OVF_BIT = 5;
  localparam int AEM_CTRL_ENERGY_OVF_BIT = 4;
  // Channel index of each threshold channel
  localparam int AEM_CH_AUX2 = 0;
  localparam int AEM_CH_AUX3 = 1;
  localparam int AEM_CH_AUX4 = 2;
  localparam int AEM_CH_GP1 = 3;
  localparam int AEM_CH_GP2 = 4;
  localparam int AEM_CH_GP3 = 5;
  localparam int AEM_CH_GP4 = 6;
  localparam int AEM_CH_OUT_SENSE = 7;
  localparam int AEM_CH_SW_NODE = 8;
  localparam int AEM_CH_AUX_DIFF_A = 9;
  localparam int AEM_CH_AUX_DIFF_B = 10;
  localparam int AEM_CH_GP_DIFF_A = 11;
  localparam int AEM_CH_GP_DIFF_B = 12;
  localparam int AEM_NUSED = 13;
  localparam logic [AEM_ENERGY_W-1:0] AEM_ENERGY_RESET = 48'h0000_0000_0000;
  localparam logic [AEM_TICK_W-1:0] AEM_TICK_RESET = 32'h0000_0000;
endpackage : aem_pkg

// ===== verilog/aem_alert_if.sv
// Purpose: Carries per-channel enables and comparison results to the alert evaluator
// Assumes: One bit per channel, indexed by the package channel numbers
// Notes: Top module drives enables, evaluator returns alert strobe
`timescale 1ns/100ps
interface aem_alert_if;
  import aem_pkg::*;
  logic [AEM_NCH-1:0] upper_en;
  logic [AEM_NCH-1:0] lower_en;
  logic [AEM_NCH-1:0] conv_done;
  logic [AEM_NCH-1:0] above_upper;
  logic [AEM_NCH-1:0] below_lower;
  logic [AEM_NCH-1:0] alert;
  modport regs (output upper_en, output lower_en, output conv_done, output above_upper,
                output below_lower, input alert);
  modport eval (input upper_en, input lower_en, input conv_done, input above_upper,
                input below_lower, output alert);
endinterface : aem_alert_if

// ===== verilog/aem_alert_eval.sv
// Purpose: Turns masked limit violations into registered per-channel alert pulses
// Assumes: Comparison results are valid in the cycle conv_done is high
// Notes: One-cycle pulse per violating conversion
`timescale 1ns/100ps
module aem_alert_eval (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Channel side
  aem_alert_if.eval ch
);
  import aem_pkg::*;
  logic [AEM_NCH-1:0] alert_q;

  // Per-channel gating; each channel judged only when its conversion lands
  genvar i;
  generate
    for (i = 0; i < AEM_NCH; i++) begin : g_ch
      always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
          alert_q[i] <= 1'b0;
        end else begin
          alert_q[i] <= ch.conv_done[i] &
                        ((ch.upper_en[i] & ch.above_upper[i]) | (ch.lower_en[i] & ch.below_lower[i]));
        end
      end
    end
  endgenerate
  assign ch.alert = alert_q;

  AST_LOWER_MASKED: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (ch.conv_done[AEM_CH_AUX2] && ch.below_lower[AEM_CH_AUX2] && !ch.lower_en[AEM_CH_AUX2]
     && !(ch.upper_en[AEM_CH_AUX2] && ch.above_upper[AEM_CH_AUX2])) |=> !alert_q[AEM_CH_AUX2])
    else $error("masked lower violation raised an alert");
  AST_ALERT_CAUSE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    alert_q[AEM_CH_GP1] |-> $past(ch.conv_done[AEM_CH_GP1]))
    else $error("alert without a completed conversion");
endmodule : aem_alert_eval

// ===== verification/aem_host_model.sv
// Purpose: Host side of the byte register port
// Assumes: Writes are one-cycle strobes, reads are combinational
// Notes: Address parks on an unmapped byte before the first access
`timescale 1ns/100ps
module aem_host_model (
  // Clock
  input wire logic ref_clk,
  // Register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  // Idle values at time zero
  initial begin
    reg_addr = 8'hff;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end

  // One byte write; data is scrambled after the taking edge so nothing stale lingers
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr

  // Read sampled mid-cycle, once address and state have settled
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask : rd
endmodule : aem_host_model

// ===== verification/aem_regs_tb.sv
// Purpose: Self-checking bench for the alert masks and energy meter
// Assumes: Host model drives the register port, bench drives conversions
// Notes: Expected masks, alerts and counters are modelled in the bench
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module aem_regs_tb;
  import aem_pkg::*;
  logic ref_clk, rst_b, reg_wr, power_done, alert_any;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rb;
  logic [AEM_POWER_W-1:0] power_value;
  logic [AEM_NCH-1:0] ch_done, ch_above_upper, ch_below_lower, ch_alert;
  logic [47:0] e_exp, v;
  logic [31:0] t_exp;
  logic [7:0] m [4];
  logic [7:0] ma [4] = '{AEM_AUX_MASK_ADDR, AEM_GP_MASK_ADDR, AEM_OUT_MASK_ADDR, AEM_DIFF_MASK_ADDR};
  logic [7:0] mb [4] = '{AEM_AUX_MASK_BITS, AEM_FULL_MASK_BITS, AEM_OUT_MASK_BITS, AEM_FULL_MASK_BITS};
  int error_cnt, checked, cyc;

  aem_regs DUT (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .power_done(power_done), .power_value(power_value),
    .ch_done(ch_done), .ch_above_upper(ch_above_upper), .ch_below_lower(ch_below_lower),
    .ch_alert(ch_alert), .alert_any(alert_any));
  aem_host_model host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  // Expected alerts: upper enables on odd mask bits, lower on even, channel order per mask
  function automatic logic [15:0] exp_alert(logic [15:0] dn, logic [15:0] up, logic [15:0] lo);
    logic [15:0] ue, le;
    ue = {3'h0, m[3][1], m[3][3], m[3][5], m[3][7], m[2][5], m[2][7], m[1][1], m[1][3], m[1][5],
          m[1][7], m[0][1], m[0][3], m[0][5]};
    le = {3'h0, m[3][0], m[3][2], m[3][4], m[3][6], m[2][4], m[2][6], m[1][0], m[1][2], m[1][4],
          m[1][6], m[0][0], m[0][2], m[0][4]};
    return dn & ((ue & up) | (le & lo));
  endfunction : exp_alert

  task automatic results();
    if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  // Write a mask and read it back; reserved bits must read zero
  task automatic setm(int i, logic [7:0] d);
    host.wr(ma[i], d);
    m[i] = d & mb[i];
    host.rd(ma[i], rb);
    `CHK(rb, m[i])
  endtask : setm

  // Multi-byte access, lowest address holds the low byte
  task automatic rdn(logic [7:0] a, int n, output logic [47:0] r);
    r = '0;
    for (int k = 0; k < n; k++) begin
      host.rd(a + 8'(k), rb);
      r[8*k +: 8] = rb;
    end
  endtask : rdn
  task automatic wrn(logic [7:0] a, int n, logic [47:0] d);
    for (int k = 0; k < n; k++) host.wr(a + 8'(k), d[8*k +: 8]);
  endtask : wrn

  task automatic chk_meter();
    rdn(AEM_ENERGY_ADDR, 6, v);
    `CHK(v, e_exp)
    rdn(AEM_TICK_ADDR, 4, v);
    `CHK(v[31:0], t_exp)
  endtask : chk_meter

  // One conversion pulse; the model only counts it when metering runs
  task automatic pulse(logic [23:0] p, bit run);
    @(posedge ref_clk);
    power_done <= 1'b1;
    power_value <= p;
    @(posedge ref_clk);
    power_done <= 1'b0;
    power_value <= ~p;
    if (run) begin
      e_exp += 48'(p);
      t_exp += 32'd1;
    end
  endtask : pulse

  // Alert is a one-cycle pulse after the taking edge
  task automatic alert(logic [15:0] dn, logic [15:0] up, logic [15:0] lo);
    @(posedge ref_clk);
    ch_done <= dn;
    ch_above_upper <= up;
    ch_below_lower <= lo;
    @(posedge ref_clk);
    ch_done <= '0;
    @(negedge ref_clk);
    `CHK(ch_alert, exp_alert(dn, up, lo))
    `CHK(alert_any, |exp_alert(dn, up, lo))
    @(negedge ref_clk);
    `CHK(ch_alert, 16'h0000)
  endtask : alert

  // Free-running clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      results();
    end
  end

  // Main sequence
  initial begin
    rst_b = 1'b0;
    power_done = 1'b0;
    power_value = '0;
    ch_done = '0;
    ch_above_upper = '0;
    ch_below_lower = '0;
    e_exp = '0;
    t_exp = '0;
    m = '{default: 8'h00};
    void'($urandom(66817));
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    // Reset values
    for (int i = 0; i < 4; i++) begin
      host.rd(ma[i], rb);
      `CHK(rb, 8'h00)
    end
    chk_meter();
    alert(16'hffff, 16'hffff, 16'hffff);
    // Walk every enable bit, upper and lower compares apart
    for (int i = 0; i < 4; i++) begin
      for (int b = 0; b < 8; b++) begin
        setm(i, 8'h01 << b);
        alert(16'hffff, 16'hffff, 16'h0000);
        alert(16'hffff, 16'h0000, 16'hffff);
      end
      setm(i, 8'h00);
    end
    // Random masks and compares
    repeat (40) begin
      setm($urandom_range(3), 8'($urandom));
      alert(16'($urandom), 16'($urandom), 16'($urandom));
    end
    // Unmapped address ignores writes and reads zero
    host.wr(8'h20, 8'h5a);
    host.rd(8'h20, rb);
    `CHK(rb, 8'h00)
    repeat (20) pulse(24'($urandom), 1'b1);
    chk_meter();
    // Halt freezes both counters, then the reset bit holds them at zero
    host.wr(AEM_CTRL_ADDR, 8'h40);
    pulse(24'h123456, 1'b0);
    chk_meter();
    host.rd(AEM_CTRL_ADDR, rb);
    `CHK(rb, 8'h40)
    host.wr(AEM_CTRL_ADDR, 8'h80);
    pulse(24'h000777, 1'b0);
    e_exp = '0;
    t_exp = '0;
    host.rd(AEM_CTRL_ADDR, rb);
    `CHK(rb, 8'h80)
    chk_meter();
    host.wr(AEM_CTRL_ADDR, 8'h00);
    pulse(24'h000007, 1'b1);
    chk_meter();
    // Preset near the top, then wrap both counters
    e_exp = 48'hffff_ffff_fff0;
    t_exp = 32'hffff_ffff;
    wrn(AEM_ENERGY_ADDR, 6, e_exp);
    wrn(AEM_TICK_ADDR, 4, 48'(t_exp));
    chk_meter();
    pulse(24'h000020, 1'b1);
    chk_meter();
    host.rd(AEM_CTRL_ADDR, rb);
    `CHK(rb, 8'h30)
    host.wr(AEM_CTRL_ADDR, 8'h00);
    host.rd(AEM_CTRL_ADDR, rb);
    `CHK(rb, 8'h00)
    // Mid-run reset must wipe written masks, a halted non-zero meter and set flags
    setm(1, 8'hff);
    pulse(24'h000100, 1'b1);
    host.wr(AEM_CTRL_ADDR, 8'h70);
    host.rd(AEM_CTRL_ADDR, rb);
    `CHK(rb, 8'h70)
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    e_exp = '0;
    t_exp = '0;
    m = '{default: 8'h00};
    for (int i = 0; i < 4; i++) begin
      host.rd(ma[i], rb);
      `CHK(rb, 8'h00)
    end
    chk_meter();
    host.rd(AEM_CTRL_ADDR, rb);
    `CHK(rb, 8'h00)
    alert(16'hffff, 16'hffff, 16'hffff);
    results();
  end
endmodule : aem_regs_tb
